/* include/rxdc_pkg.sv */
// types for the receiver duty cycle and power level block
// assumes rxdc_regs.svh is included alongside
package rxdc_pkg;
	typedef enum logic [1:0] {
		RXDC_ALWAYS_ON,
		RXDC_LISTEN,
		RXDC_HOLD,
		RXDC_STANDBY
	} rxdc_state_t;
endpackage : rxdc_pkg

/* include/rxdc_regs.svh */
// constants for the receiver duty cycle and power level block
// assumes a 125 MHz ref_clk and a digitised output_level_input sample
`ifndef RXDC_REGS_SVH
`define RXDC_REGS_SVH

`define RXDC_CLK_HZ        125000000
`define RXDC_SEC_CYCLES    125000000
`define RXDC_LISTEN_MS     326
`define RXDC_LISTEN_CYCLES ((`RXDC_CLK_HZ / 1000) * `RXDC_LISTEN_MS)
`define RXDC_LEVEL_STEPS   58
`define RXDC_LEVEL_MAX     6'h39
`define RXDC_LEVEL_W       6
`define RXDC_ADC_W         10
`define RXDC_SECS_W        8

`endif

/* logic/rxdc_core.sv */
// receiver duty cycling and power-up transmit level selection
// assumes config inputs come from the serial command decoder
`timescale 1ns/1ps
`include "rxdc_regs.svh"

module rxdc_core #(
	parameter int unsigned SEC_CYCLES    = `RXDC_SEC_CYCLES,
	parameter int unsigned LISTEN_CYCLES = `RXDC_LISTEN_CYCLES
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_b,
	input  wire logic [`RXDC_ADC_W-1:0]     output_level_input,
	input  wire logic                       level_sample_valid,
	input  wire logic                       duty_enable,
	input  wire logic [`RXDC_SECS_W-1:0]    sleep_period_seconds,
	input  wire logic [`RXDC_SECS_W-1:0]    awake_hold_seconds,
	input  wire logic                       rx_mode,
	input  wire logic                       rx_valid_packet,
	input  wire logic                       rx_data_active,
	input  wire logic                       tx_done,
	output logic [`RXDC_LEVEL_W-1:0]        power_level,
	output logic                            power_level_valid,
	output logic                            rx_power_on,
	output rxdc_pkg::rxdc_state_t           duty_state
);
	import rxdc_pkg::*;

	// ------------------------------------------------------------
	// power-up level capture
	// ------------------------------------------------------------
	logic [`RXDC_LEVEL_W-1:0] next_power_level;
	logic                     next_power_level_valid;
	logic [`RXDC_ADC_W+5:0]   scaled;

	always_comb begin
		// full-scale adc reading maps to 57, ground to 0
		scaled = {6'h00, output_level_input} * 16'(`RXDC_LEVEL_STEPS);
		next_power_level       = power_level;
		next_power_level_valid = power_level_valid;
		if (!power_level_valid && level_sample_valid) begin
			next_power_level_valid = 1'b1;
			if (&output_level_input) begin
				next_power_level = `RXDC_LEVEL_MAX;
			end else begin
				next_power_level = scaled[`RXDC_ADC_W+5:`RXDC_ADC_W];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			power_level       <= 6'h00;
			power_level_valid <= 1'b0;
		end else begin
			power_level       <= next_power_level;
			power_level_valid <= next_power_level_valid;
		end
	end

	// ------------------------------------------------------------
	// one second tick
	// ------------------------------------------------------------
	// restarted at turn-on and on activity so periods and hold
	// times are whole seconds from their own start
	logic [31:0] sec_cnt;
	logic [31:0] next_sec_cnt;
	logic        sec_tick;
	logic        tick_restart;

	always_comb begin
		sec_tick = (sec_cnt == SEC_CYCLES - 1);
		if (tick_restart || sec_tick) begin
			next_sec_cnt = 32'h0000_0000;
		end else begin
			next_sec_cnt = sec_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_cnt <= 32'h0000_0000;
		end else begin
			sec_cnt <= next_sec_cnt;
		end
	end

	// ------------------------------------------------------------
	// activity decode
	// ------------------------------------------------------------
	logic activity;
	logic busy;
	logic duty_on;

	always_comb begin
		activity = tx_done | rx_valid_packet;
		busy     = activity | rx_data_active;
		duty_on  = duty_enable & rx_mode;
	end

	// ------------------------------------------------------------
	// duty cycle sequencer
	// ------------------------------------------------------------
	// period counted from turn-on, or from hold end, so standby after listen = period - listen
	rxdc_state_t             state;
	rxdc_state_t             next_state;
	logic [31:0]             win_cnt;
	logic [31:0]             next_win_cnt;
	logic [`RXDC_SECS_W-1:0] per_secs;
	logic [`RXDC_SECS_W-1:0] next_per_secs;
	logic [`RXDC_SECS_W-1:0] hold_secs;
	logic [`RXDC_SECS_W-1:0] next_hold_secs;
	logic                    period_done;
	logic                    hold_done;
	logic                    listen_done;
	logic                    next_rx_power_on;

	always_comb begin
		period_done = sec_tick &&
		              (per_secs + 8'h01 >= sleep_period_seconds);
		hold_done   = sec_tick &&
		              (hold_secs + 8'h01 >= awake_hold_seconds);
		listen_done = (win_cnt >= LISTEN_CYCLES - 1);
		next_state     = state;
		next_win_cnt   = win_cnt;
		next_per_secs  = per_secs;
		next_hold_secs = hold_secs;
		tick_restart   = 1'b0;
		if (sec_tick) begin
			next_per_secs = per_secs + 8'h01;
		end
		case (state)
			RXDC_ALWAYS_ON: begin
				if (duty_on) begin
					next_state    = RXDC_LISTEN;
					next_win_cnt  = 32'h0000_0000;
					next_per_secs = 8'h00;
					tick_restart  = 1'b1;
				end
			end
			RXDC_LISTEN: begin
				next_win_cnt = win_cnt + 32'h0000_0001;
				if (busy) begin
					next_state     = RXDC_HOLD;
					next_hold_secs = 8'h00;
					tick_restart   = 1'b1;
				end else if (listen_done) begin
					// no restart: the period runs on from the turn-on
					next_state = RXDC_STANDBY;
				end
			end
			RXDC_HOLD: begin
				// tx activity also restarts hold
				if (busy) begin
					next_hold_secs = 8'h00;
					tick_restart   = 1'b1;
				end else if (hold_done) begin
					next_state    = RXDC_STANDBY;
					next_per_secs = 8'h00;
					tick_restart  = 1'b1;
				end else if (sec_tick) begin
					next_hold_secs = hold_secs + 8'h01;
				end
			end
			RXDC_STANDBY: begin
				if (period_done) begin
					next_state    = RXDC_LISTEN;
					next_win_cnt  = 32'h0000_0000;
					next_per_secs = 8'h00;
					tick_restart  = 1'b1;
				end
			end
			default: begin
				next_state = RXDC_ALWAYS_ON;
			end
		endcase
		if (!duty_on) begin
			next_state = RXDC_ALWAYS_ON;
		end
		next_rx_power_on = (next_state != RXDC_STANDBY);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= RXDC_ALWAYS_ON;
			win_cnt   <= 32'h0000_0000;
			per_secs  <= 8'h00;
			hold_secs <= 8'h00;
		end else begin
			state     <= next_state;
			win_cnt   <= next_win_cnt;
			per_secs  <= next_per_secs;
			hold_secs <= next_hold_secs;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// registered so the power switch cannot glitch on a state decode
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_power_on <= 1'b1;
		end else begin
			rx_power_on <= next_rx_power_on;
		end
	end

	assign duty_state = state;
endmodule : rxdc_core

/* tb/rxdc_core_bench.sv */
// bench for rxdc_core with a host model
// assumes SEC_CYCLES 100 and LISTEN_CYCLES 30
`timescale 1ns/1ps
module rxdc_core_bench;
	import rxdc_pkg::*;
	int n_fail = 0, n_compared = 0, n, m;
	logic ref_clk = 0, rst_b = 0, vld = 0, rxm = 0, pkt = 0, act = 0, go = 0;
	logic txd = 0;
	logic [9:0] adc = 0;
	logic [7:0] per, hld;
	logic [5:0] lvl;
	logic de, lvl_ok, pwr;
	rxdc_state_t st;
	initial forever #4 ref_clk = ~ref_clk;
	rxdc_host_model i_rxdc_host_model (.ref_clk(ref_clk), .host_en(go),
		.duty_enable(de), .sleep_period_seconds(per), .awake_hold_seconds(hld));
	rxdc_core #(.SEC_CYCLES(100), .LISTEN_CYCLES(30)) i_rxdc_core (
		.ref_clk(ref_clk), .rst_b(rst_b), .output_level_input(adc),
		.level_sample_valid(vld), .duty_enable(de), .sleep_period_seconds(per),
		.awake_hold_seconds(hld), .rx_mode(rxm), .rx_valid_packet(pkt),
		.rx_data_active(act), .tx_done(txd), .power_level(lvl),
		.power_level_valid(lvl_ok), .rx_power_on(pwr), .duty_state(st));
	task check(logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task wait_st(rxdc_state_t s, int lim, output int k);
		k = 0;
		while (st !== s && k < lim) begin @(posedge ref_clk); #1 k++; end
	endtask : wait_st
	// later sample differs, so a resample would show
	task t_level(logic [9:0] v, logic [5:0] e);
		@(posedge ref_clk) rst_b <= 0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1; adc <= v; vld <= 1;
		@(posedge ref_clk) adc <= ~v;
		repeat (2) @(posedge ref_clk) vld <= 0;
		#1;
		check({2'h0, lvl}, {2'h0, e});
		check({7'h0, lvl_ok}, 8'h01);
		$display("level test done");
	endtask : t_level
	task t_duty;
		@(posedge ref_clk) go <= 1; rxm <= 1;
		wait_st(RXDC_LISTEN, 9, n);
		wait_st(RXDC_STANDBY, 99, n);
		check(8'(n), 8'h1e);
		check({7'h0, pwr}, 8'h00);
		wait_st(RXDC_LISTEN, 400, m);
		// tick restarts at turn-on, so the spacing is exact
		check(8'(n + m), 8'hc8);
		$display("duty test done");
	endtask : t_duty
	task t_hold;
		@(posedge ref_clk) pkt <= 1; act <= 1;
		@(posedge ref_clk) pkt <= 0;
		repeat (300) @(posedge ref_clk);
		#1 check({6'h0, st}, {6'h0, RXDC_HOLD});
		@(posedge ref_clk) act <= 0;
		repeat (50) @(posedge ref_clk);
		txd <= 1;
		@(posedge ref_clk) txd <= 0;
		wait_st(RXDC_STANDBY, 210, n);
		check(8'(n), 8'h64);
		check({6'h0, st}, {6'h0, RXDC_STANDBY});
		wait_st(RXDC_LISTEN, 300, m);
		check(8'(m), 8'hc8);
		$display("hold test done");
	endtask : t_hold
	initial begin
		t_level(10'h3ff, 6'h39);
		t_level(10'h000, 6'h00);
		t_level(10'h200, 6'h1d);
		t_duty;
		t_hold;
		tally_and_finish;
	end
	initial begin
		#40000;
		n_fail++;
		tally_and_finish;
	end
endmodule : rxdc_core_bench

/* tb/rxdc_core_monitor.sv */
// port checker for rxdc_core
// assumes one clock domain, bound below
`timescale 1ns/1ps
`include "rxdc_regs.svh"
module rxdc_core_monitor
	import rxdc_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = 100,
	parameter int unsigned LISTEN_CYCLES = 30
) (
	input wire logic                   ref_clk,
	input wire logic                   rst_b,
	input wire logic [`RXDC_ADC_W-1:0] output_level_input,
	input wire logic                   level_sample_valid,
	input wire logic                   duty_enable,
	input wire logic                   rx_mode,
	input wire logic                   rx_data_active,
	input wire logic                   rx_valid_packet,
	input wire logic                   tx_done,
	input wire logic [5:0]             power_level,
	input wire logic                   power_level_valid,
	input wire logic                   rx_power_on,
	input wire rxdc_state_t            duty_state
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	int unsigned lcnt;
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b) lcnt <= 0;
		else lcnt <= (duty_state == RXDC_LISTEN) ? lcnt + 1 : 0;
	sequence take_s;
		!power_level_valid && level_sample_valid;
	endsequence
	lvl_take_a: assert property (take_s |=> power_level_valid)
		else $error("level not taken");
	lvl_top_a: assert property (take_s ##0 &output_level_input
		|=> power_level == 6'h39) else $error("top level wrong");
	lvl_low_a: assert property (take_s ##0 output_level_input == 0
		|=> power_level == 6'h00) else $error("low level wrong");
	lvl_range_a: assert property (power_level <= 6'h39)
		else $error("level out of range");
	lvl_hold_a: assert property (power_level_valid
		|=> power_level_valid && $stable(power_level)) else $error("level moved");
	rx_off_a: assert property (
		rx_power_on == (duty_state != RXDC_STANDBY))
		else $error("rx power wrong");
	listen_len_a: assert property (lcnt <= LISTEN_CYCLES)
		else $error("listen too long");
	wake_stay_a: assert property (
		duty_state inside {RXDC_LISTEN, RXDC_HOLD} && rx_data_active
		&& duty_enable && rx_mode |=> duty_state == RXDC_HOLD)
		else $error("not kept awake");
	drop_a: assert property (
		!duty_enable |=> duty_state == RXDC_ALWAYS_ON)
		else $error("disable ignored");
	sequence busy_hold_s;
		duty_state == RXDC_HOLD && (tx_done || rx_valid_packet)
		&& duty_enable && rx_mode;
	endsequence
	hold_tx_a: assert property (busy_hold_s |=> duty_state == RXDC_HOLD)
		else $error("activity did not hold");
endmodule : rxdc_core_monitor
bind rxdc_core rxdc_core_monitor #(.SEC_CYCLES(SEC_CYCLES),
	.LISTEN_CYCLES(LISTEN_CYCLES)) i_rxdc_core_monitor (.*);

/* tb/rxdc_host_model.sv */
// host side: duty cycle settings as plain levels
// assumes the serial decoder is abstracted away
`timescale 1ns/1ps
module rxdc_host_model (
	input  wire logic       ref_clk,
	input  wire logic       host_en,
	output logic            duty_enable,
	output logic [7:0]      sleep_period_seconds,
	output logic [7:0]      awake_hold_seconds
);
	initial begin
		duty_enable = 1'h0;
		sleep_period_seconds = 8'h02;
		awake_hold_seconds = 8'h01;
		forever @(posedge ref_clk) duty_enable <= host_en;
	end
endmodule : rxdc_host_model
